// File: rtl/cms_sequencer.sv
// Charge mode sequencer: fast or trickle selection with backup timer.
// Assumes comparator results arrive synchronous to clk_sys.
//
// How it works
// - Entering the 1.0-2.0 V window selects fast and pulses timer/OT reset.
// - Two consecutive slope events in window after 160 s holdoff latch trickle.
// - Latched trickle clears only on window entry, supply rising past 3 V or a control register pulse.
// - Sense outside window gives unlatched trickle, reassessed every cycle.
// - Timer backup past its programmed limit latches trickle.
// - Fast only with sense in window, supply good, backup within limits.
// - In temperature mode, under-temperature holds unlatched trickle; fast returns once it clears.
// - In temperature mode, over-temperature sets a latch; only a reset pulse or supply below 2.8 V releases it.
// - Supply below 2.8 V forces trickle and resets timer and OT latch.
// - Backup timer is a 34-stage chain; full count means 283 minutes.
// - Sense below 1.0 V bypasses 19 timer stages.
// - With switch one, limit expiry latches after 8.1 to 32.3 ms.
// - Sense low plus upper input at -100 mV bypasses 11 timer stages.
// - Switch two gives the nominal 338.8 ms check of the lower stages.
// - Switch 3A bypasses 5 sample-gate stages, 32 times faster.
// - Switch 3B bypasses 11 holdoff stages, 2048 times faster.
// - Both switch three sections follow the upper input at -100 mV.
// - Any programming input high or open selects timer backup.
// - Three programming inputs pick one of seven limits, 71-283 minutes.
// - Latched trickle drives the mode output low until reset.
`timescale 1ns/1ps
module cms_sequencer
  import cms_pkg::*;
#(
  parameter longint SAMPLE_TICKS_P = SAMPLE_TICKS,
  parameter longint HOLDOFF_TICKS_P = HOLDOFF_TICKS
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Comparator results.
  input wire cms_sense_t sense,
  // Outputs to the power stage.
  output logic fastMode,
  output logic sampleGateOut,
  // Wishbone slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);

  localparam logic [7:0] BASE_CYC = 8'(BASE_TICK_CYC);

  // Base tick divider.
  logic [7:0] tickCnt;
  logic [7:0] next_tickCnt;
  logic baseTick;
  logic next_baseTick;

  always_comb
  begin
    next_tickCnt = tickCnt + 8'h01;
    next_baseTick = 1'b0;
    if (tickCnt == BASE_CYC - 8'h01)
    begin
      next_tickCnt = 8'h00;
      next_baseTick = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      tickCnt <= 8'h00;
      baseTick <= 1'b0;
    end
    else
    begin
      tickCnt <= next_tickCnt;
      baseTick <= next_baseTick;
    end
  end

  // Input sampling and edge detection.
  cms_sense_t senseQ;
  logic inWindowQ;
  logic vccAbove3Q;
  logic inWindow;
  logic timerMode;
  logic resetPulse;
  logic swPulse;
  logic timerClear;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      senseQ <= '0;
      // The cleared sample reads as inside, so no false entry follows reset.
      inWindowQ <= 1'b1;
      vccAbove3Q <= 1'b0;
    end
    else
    begin
      senseQ <= sense;
      inWindowQ <= inWindow;
      vccAbove3Q <= senseQ.vccAbove3;
    end
  end

  assign inWindow = !senseQ.senseLow && !senseQ.senseHigh;
  assign timerMode = senseQ.progUpper || senseQ.progThermal ||
    senseQ.progLower;
  // Single-cycle pulse on window entry, supply recovery or a control register pulse.
  assign resetPulse = (inWindow && !inWindowQ) ||
    (senseQ.vccAbove3 && !vccAbove3Q) || swPulse;
  assign timerClear = resetPulse || senseQ.vccUvlo;

  // Timer chain with test bypass.
  logic sw1;
  logic sw2;
  logic sw3;
  logic [5:0] timerSkip;
  logic [TIMER_STAGES:0] timerLimit;
  logic [TIMER_STAGES:0] timerCount;
  logic timerDone;
  logic [3:0] limitEighths;

  assign sw1 = senseQ.senseLow;
  assign sw2 = senseQ.senseLow && senseQ.upperRefNeg;
  assign sw3 = senseQ.upperRefNeg;
  // Second switch exercises the stages that the first one hides.
  assign timerSkip = sw2 ? 6'(SW2_SKIP) :
    (sw1 ? 6'(SW1_SKIP) : 6'h00);
  assign limitEighths = {1'b0, senseQ.progLower, senseQ.progThermal,
    senseQ.progUpper} + 4'h1;
  assign timerLimit = (TIMER_STAGES+1)'(limitEighths) << LIMIT_SHIFT;

  cms_stage_counter #(.WIDTH(TIMER_STAGES)) u_timer
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(timerClear),
    .tick(baseTick && timerMode),
    .skip(timerSkip),
    .limit(timerLimit),
    .count(timerCount),
    .done(timerDone)
  );

  // Sample gate divider.
  localparam int SW = 24;
  localparam int HW = 30;
  logic [SW:0] sampleCount;
  logic sampleDone;

  cms_stage_counter #(.WIDTH(SW)) u_sample
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(sampleDone),
    .tick(baseTick),
    .skip(sw3 ? 6'(SW3A_SKIP) : 6'h00),
    .limit((SW+1)'(SAMPLE_TICKS_P)),
    .count(sampleCount),
    .done(sampleDone)
  );

  // Holdoff timer, restarted with every reset pulse.
  logic [HW:0] holdCount;
  logic holdDone;

  cms_stage_counter #(.WIDTH(HW)) u_holdoff
  (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(timerClear),
    .tick(baseTick),
    .skip(sw3 ? 6'(SW3B_SKIP) : 6'h00),
    .limit((HW+1)'(HOLDOFF_TICKS_P)),
    .count(holdCount),
    .done(holdDone)
  );

  // Consecutive negative slope tracking.
  logic eventSeen;
  logic next_eventSeen;
  logic [1:0] nsCount;
  logic [1:0] next_nsCount;
  logic slopeFull;

  always_comb
  begin
    // A new event wins over the clear at the sample gate.
    next_eventSeen = senseQ.negSlopeEvent || (eventSeen && !sampleDone);
    next_nsCount = nsCount;
    if (!inWindow || resetPulse)
      next_nsCount = 2'h0;
    else if (sampleDone)
    begin
      if (eventSeen || senseQ.negSlopeEvent)
        next_nsCount = (nsCount == 2'(NS_EVENTS_NEEDED)) ?
          nsCount : nsCount + 2'h1;
      else
        next_nsCount = 2'h0;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      eventSeen <= 1'b0;
      nsCount <= 2'h0;
    end
    else
    begin
      eventSeen <= next_eventSeen;
      nsCount <= next_nsCount;
    end
  end

  assign slopeFull = inWindow && holdDone &&
    (nsCount == 2'(NS_EVENTS_NEEDED));

  // Over-temperature latch.
  logic otLatch;
  logic next_otLatch;

  always_comb
  begin
    next_otLatch = otLatch;
    if (!timerMode && senseQ.overTemp)
      next_otLatch = 1'b1;
    else if (timerClear)
      next_otLatch = 1'b0;
    // Supply lockout is a true reset and holds the latch clear.
    if (senseQ.vccUvlo)
      next_otLatch = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      otLatch <= 1'b0;
    else
      otLatch <= next_otLatch;
  end

  // Control register and mode state.
  logic forceTrickle;
  logic next_forceTrickle;
  logic next_swPulse;
  cms_mode_t mode;
  cms_mode_t next_mode;
  logic fastOk;
  logic latchSet;
  logic next_fastMode;

  // Every set source is cleared by the pulse, so stale values must not
  // outvote it, or a timer expiry could never be released.
  assign latchSet = !resetPulse &&
    (slopeFull || (timerMode && timerDone));
  assign fastOk = inWindow && senseQ.vccAbove3 && !senseQ.vccUvlo &&
    !otLatch && !forceTrickle &&
    !(!timerMode && senseQ.underTemp);

  always_comb
  begin
    next_mode = mode;
    case (mode)
      ST_TRICKLE:
        if (latchSet && !senseQ.vccUvlo)
          next_mode = ST_LATCHED;
        else if (fastOk)
          next_mode = ST_FAST;
      ST_FAST:
        if (latchSet && !senseQ.vccUvlo)
          next_mode = ST_LATCHED;
        else if (!fastOk)
          next_mode = ST_TRICKLE;
      ST_LATCHED:
        if (resetPulse && !latchSet)
          next_mode = ST_TRICKLE;
      default:
        next_mode = ST_TRICKLE;
    endcase
    next_fastMode = (next_mode == ST_FAST);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      mode <= ST_TRICKLE;
      fastMode <= 1'b0;
      sampleGateOut <= 1'b0;
    end
    else
    begin
      mode <= next_mode;
      fastMode <= next_fastMode;
      sampleGateOut <= sampleDone;
    end
  end

  // Wishbone slave: ack one cycle after the strobe, dropped next cycle.
  logic [31:0] next_dat;
  logic next_ack;
  logic wbReq;
  logic [31:0] statusWord;

  assign wbReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign statusWord = {20'h00000, nsCount, holdDone, timerDone,
    timerMode, inWindow, otLatch, mode == ST_LATCHED,
    mode == ST_FAST, sw3, sw2, sw1};

  always_comb
  begin
    next_ack = wbReq;
    next_dat = 32'h00000000;
    next_forceTrickle = forceTrickle;
    next_swPulse = 1'b0;
    if (wbReq)
    begin
      case (wb_adr_i)
        ADDR_CTRL:
        begin
          next_dat = {30'h0, 1'b0, forceTrickle};
          if (wb_we_i && wb_sel_i[0])
          begin
            next_forceTrickle = wb_dat_i[CTRL_FORCE_BIT];
            next_swPulse = wb_dat_i[CTRL_PULSE_BIT];
          end
        end
        ADDR_STATUS:
          next_dat = statusWord;
        ADDR_TIMER:
          next_dat = timerCount[TIMER_STAGES:TIMER_STAGES-31];
        default:
          next_dat = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      forceTrickle <= CTRL_RESET[CTRL_FORCE_BIT];
      swPulse <= 1'b0;
    end
    else
    begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_dat;
      forceTrickle <= next_forceTrickle;
      swPulse <= next_swPulse;
    end
  end

endmodule

// File: rtl/cms_pkg.sv
// Shared constants and types of the charge mode sequencer.
// Assumes a 50 MHz system clock and comparator results already qualified.
package cms_pkg;

  // System clock and the base tick of the backup timer chain.
  localparam longint CLK_HZ = 50000000;
  localparam longint TIMER_FULL_MIN = 283;
  localparam int TIMER_STAGES = 34;
  // Cycles per base tick: a full 34-stage count spans 283 minutes.
  localparam longint BASE_TICK_CYC =
    (TIMER_FULL_MIN * 60 * CLK_HZ) >> TIMER_STAGES;
  localparam longint SAMPLE_PERIOD_MS = 1380;
  localparam longint HOLDOFF_S = 160;
  localparam longint SAMPLE_TICKS =
    (SAMPLE_PERIOD_MS * (CLK_HZ / 1000)) / BASE_TICK_CYC;
  localparam longint HOLDOFF_TICKS = (HOLDOFF_S * CLK_HZ) / BASE_TICK_CYC;
  // Nominal test figures, kept for the bench.
  localparam int SW1_SKIP = 19;
  localparam int SW2_SKIP = 11;
  localparam int SW3A_SKIP = 5;
  localparam int SW3B_SKIP = 11;
  localparam int SW1_MAX_DELAY_US = 32300;
  localparam int SW2_DELAY_US = 338800;
  // Limit is code-plus-one eighths of the full count.
  localparam int LIMIT_SHIFT = 31;
  localparam int NS_EVENTS_NEEDED = 2;

  // Register map, byte addresses.
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_TIMER = 8'h08;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam int CTRL_FORCE_BIT = 0;
  localparam int CTRL_PULSE_BIT = 1;

  typedef enum logic [1:0] {ST_TRICKLE, ST_FAST, ST_LATCHED} cms_mode_t;

  // Qualified comparator results.
  typedef struct packed {
    logic senseLow;      // cell_voltage_sense below 1.0 V
    logic senseHigh;     // cell_voltage_sense above 2.0 V
    logic vccAbove3;     // supply above 3.0 V
    logic vccUvlo;       // supply below 2.8 V
    logic progUpper;     // prog_in_upper above select threshold or open
    logic progThermal;   // prog_in_thermal above select threshold or open
    logic progLower;     // prog_in_lower above select threshold or open
    logic upperRefNeg;   // prog_in_upper biased at -100 mV
    logic underTemp;
    logic overTemp;
    logic negSlopeEvent; // one-cycle pulse per detected negative slope
  } cms_sense_t;

endpackage

// File: rtl/cms_stage_counter.sv
// Divider chain with bypassable low stages and a programmable end count.
// Assumes tick is a one-cycle enable; clear wins over tick.
`timescale 1ns/1ps
module cms_stage_counter
  import cms_pkg::*;
#(
  parameter int WIDTH = 34
)
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Control.
  input wire logic clear,
  input wire logic tick,
  input wire logic [5:0] skip,
  input wire logic [WIDTH:0] limit,
  // Result.
  output logic [WIDTH:0] count,
  output logic done
);

  logic [WIDTH:0] next_count;
  logic next_done;
  logic [WIDTH+1:0] sum;

  always_comb
  begin
    // Bypassing stages is a larger step, so the chain reaches the end early.
    sum = {1'b0, count} + ({{(WIDTH+1){1'b0}}, 1'b1} << skip);
    next_count = count;
    if (clear)
      next_count = '0;
    else if (tick && !done)
      next_count = (sum >= {1'b0, limit}) ? limit : sum[WIDTH:0];
    next_done = !clear && (next_count >= limit);
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= '0;
      done <= 1'b0;
    end
    else
    begin
      count <= next_count;
      done <= next_done;
    end
  end

endmodule

// File: verif/cms_power_stage.sv
// Model of the external power stage fed by the mode output.
// Assumes the gate output interrupts the charge current while high.
`timescale 1ns/1ps
module cms_power_stage
(
  // From the sequencer.
  input wire logic fastMode,
  input wire logic sampleGateOut,
  // Charge current: 0 off, 1 trickle, 2 fast.
  output logic [1:0] currentLvl
);
  // The gate wins so that the cell is sensed with no current flowing.
  assign currentLvl = sampleGateOut ? 2'h0 : (fastMode ? 2'h2 : 2'h1);
endmodule

// File: verif/cms_sequencer_props.sv
// Checker for the charge mode sequencer ports.
// Assumes it is bound into every sequencer instance.
`timescale 1ns/1ps
module cms_sequencer_props
  import cms_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Watched ports.
  input wire cms_sense_t sense,
  input wire logic fastMode,
  input wire logic sampleGateOut,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  logic inWin;
  logic tempMode;
  logic good;
  assign inWin = !sense.senseLow && !sense.senseHigh;
  assign tempMode = !(sense.progUpper || sense.progThermal || sense.progLower);
  assign good = inWin && sense.vccAbove3 && !sense.vccUvlo &&
    !(tempMode && (sense.underTemp || sense.overTemp));
  sequence entry_s;
    !inWin ##1 good [*4];
  endsequence
  sequence hot_s;
    tempMode && sense.overTemp && inWin && !sense.vccUvlo;
  endsequence
  sequence hold_s;
    (inWin && !sense.vccUvlo && $stable(sense.vccAbove3)) [*4];
  endsequence
  window_entry_a: assert property (entry_s |-> fastMode)
    else $error("fast mode missing after window entry");
  outside_trickle_a: assert property (!inWin |-> ##2 !fastMode)
    else $error("fast mode outside the window");
  uvlo_trickle_a: assert property (sense.vccUvlo |-> ##2 !fastMode)
    else $error("fast mode during undervoltage");
  fast_cause_a: assert property (fastMode |->
    $past(inWin && !sense.vccUvlo, 2))
    else $error("fast mode without its conditions");
  cold_hold_a: assert property (tempMode && sense.underTemp |->
    ##2 !fastMode)
    else $error("fast mode while under temperature");
  hot_latch_a: assert property (hot_s ##1 hold_s |-> !fastMode)
    else $error("over temperature latch released");
  gate_pulse_a: assert property ($rose(sampleGateOut) |=>
    !sampleGateOut [*8])
    else $error("gate pulse too long");
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not a single pulse");
endmodule
bind cms_sequencer cms_sequencer_props u_props (.clk_sys(clk_sys),
  .rstn(rstn), .sense(sense), .fastMode(fastMode),
  .sampleGateOut(sampleGateOut), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o));

// File: verif/cms_sequencer_tb.sv
// Self-checking bench for the charge mode sequencer.
// Assumes the bound checker and the power stage model beside the design.
`timescale 1ns/1ps
module cms_sequencer_tb;
  import cms_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  cms_sense_t sense = '0;
  cms_sense_t s = '0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [3:0] wbSel = 4'h0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic [31:0] r;
  logic [7:0] adr;
  logic wbAck;
  logic fastMode;
  logic gate;
  logic [1:0] currentLvl;
  logic [63:0] dataQ[$];
  logic [1:0] modeQ[$];
  int fail_count = 0;
  int cmp_count = 0;
  event modeChk;

  always #10 clk_sys = ~clk_sys;

  cms_sequencer #(.SAMPLE_TICKS_P(20), .HOLDOFF_TICKS_P(50)) u_dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .sense(sense),
    .fastMode(fastMode),
    .sampleGateOut(gate),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_we_i(wbWe),
    .wb_adr_i(wbAdr),
    .wb_sel_i(wbSel),
    .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO),
    .wb_ack_o(wbAck)
  );
  cms_power_stage u_stage (
    .fastMode(fastMode),
    .sampleGateOut(gate),
    .currentLvl(currentLvl)
  );

  task automatic report_and_stop();
    $display("Counts: %0d compared, %0d failed", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic fail(string msg);
    fail_count++;
    $display("Error at %0t: %s", $time, msg);
  endtask
  task automatic cmp_data(logic [31:0] got, logic [63:0] note);
    cmp_count++;
    if ((got & note[63:32]) !== note[31:0])
      fail("read data mismatch");
  endtask
  task automatic cmp_mode(logic [1:0] got, logic [1:0] exp);
    cmp_count++;
    if (got !== exp)
      fail("charge level mismatch");
  endtask
  // Every wait is bounded; running out ends the run as a failure.
  task automatic wait_hi(input bit onGate, input int lim);
    int n;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while ((onGate ? gate : wbAck) !== 1'b1 && n < lim);
    if ((onGate ? gate : wbAck) !== 1'b1)
    begin
      fail("wait timed out");
      report_and_stop();
    end
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d,
    logic [31:0] m, logic [31:0] e);
    if (!we)
      dataQ.push_back({m, e});
    @(posedge clk_sys);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbSel <= 4'hf;
    wbAdr <= a;
    wbDatI <= d;
    wait_hi(1'b0, 20);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic apply();
    @(posedge clk_sys);
    sense <= s;
  endtask
  // Sampled on a falling edge, clear of any gate pulse.
  task automatic mode(logic exp);
    repeat (4) @(posedge clk_sys);
    @(negedge clk_sys);
    if (gate === 1'b1)
      @(negedge clk_sys);
    modeQ.push_back(exp ? 2'h2 : 2'h1);
    -> modeChk;
  endtask

  always @(posedge clk_sys)
    if (wbAck === 1'b1 && wbWe === 1'b0 && dataQ.size() > 0)
      cmp_data(wbDatO, dataQ.pop_front());
  always @(modeChk)
    cmp_mode(currentLvl, modeQ.pop_front());

  initial
  begin
    void'($urandom(32'hf725));
    s.senseLow = 1'b1;
    s.vccAbove3 = 1'b1;
    sense = s;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    wb(0, ADDR_CTRL, 0, 32'hffffffff, 0);
    r = $urandom();
    wb(1, ADDR_CTRL, r, 0, 0);
    wb(0, ADDR_CTRL, 0, 32'hffffffff, {31'h0, r[0]});
    adr = {6'($urandom_range(63, 3)), 2'b00};
    wb(1, adr, r, 0, 0);
    wb(0, adr, 0, 32'hffffffff, 0);
    s.upperRefNeg = 1'b1;
    apply();
    wb(0, ADDR_STATUS, 0, 32'h7, 32'h7);
    s.upperRefNeg = 1'b0;
    wb(1, ADDR_CTRL, 0, 0, 0);
    $display("Test registers done");
    s.senseLow = 1'b0;
    apply();
    mode(1);
    s.senseHigh = 1'b1;
    apply();
    mode(0);
    s.senseHigh = 1'b0;
    apply();
    mode(1);
    wb(1, ADDR_CTRL, 1, 0, 0);
    mode(0);
    wb(1, ADDR_CTRL, 0, 0, 0);
    mode(1);
    wb(0, ADDR_STATUS, 0, 32'h8f, 32'h08);
    $display("Test window done");
    s.progLower = 1'b1;
    s.overTemp = 1'b1;
    apply();
    mode(1);
    wb(0, ADDR_STATUS, 0, 32'h80, 32'h80);
    s.progLower = 1'b0;
    s.overTemp = 1'b0;
    apply();
    s.vccUvlo = 1'b1;
    apply();
    mode(0);
    s.vccUvlo = 1'b0;
    apply();
    mode(1);
    s.underTemp = 1'b1;
    apply();
    mode(0);
    s.underTemp = 1'b0;
    apply();
    mode(1);
    s.overTemp = 1'b1;
    apply();
    s.overTemp = 1'b0;
    apply();
    mode(0);
    repeat (50) @(posedge clk_sys);
    mode(0);
    s.vccAbove3 = 1'b0;
    apply();
    s.vccAbove3 = 1'b1;
    apply();
    mode(1);
    $display("Test supply and temperature done");
    repeat (3000) @(posedge clk_sys);
    repeat (3)
    begin
      wait_hi(1'b1, 2000);
      s.negSlopeEvent = 1'b1;
      apply();
      s.negSlopeEvent = 1'b0;
      apply();
    end
    mode(0);
    repeat (100) @(posedge clk_sys);
    mode(0);
    s.senseLow = 1'b1;
    apply();
    s.senseLow = 1'b0;
    apply();
    mode(1);
    $display("Test slope latch done");
    // Let the compare process take the last note before the verdict.
    repeat (2) @(posedge clk_sys);
    report_and_stop();
  end
endmodule
